// ==== design/rde_config_bank.sv ====
//
// Purpose: Setting and status registers for relays, digital outputs and unit data.
// Assumes: A protocol handler issues single-word reads and writes on the reg port.
// Notes:   Unit and log areas are fetched from an outside store on the fetch port.
//
// How it works
// - Operation bit 2 turns the bypass charger on when set; set by default.
// - Operation bit 3 feeds battery to grid on grid-tied models; clear by default.
// - Settings the model lacks read back as zero.
// - Config bits 1:0 pick UPS, saving or solar mode; 3 is reserved.
// - Config bits 3:2 pick utility or solar charging; others reserved.
// - Relay word: delay bits 3:0, trigger 7:4, source 11:8.
// - Source 0 alarm, 2 inverter state, 3-7 input channels one to five.
// - Output word: delay 3:0, action 7:4, trigger 11:8, source 15:12.
// - Relay status bits 3:0 give relays one to four, 1 means shorted.
// - IO status low byte gives outputs, high byte gives inputs.
// - Numeric area returns one word per unit index 0 to 191.
// - Inverter numeric commands 0x00 to 0x06 select measured values.
// - Inverter string commands 0x80 to 0x82 return model, version, status.
// - Log entries are at most 62 bytes; an empty entry reads zero.
// - A record holds name, comma, event, comma, date, space, time, newline.
// - System records name one of six events.
// - Inverter records from units 0-31 name one of twelve events.
// - Relay status is read at word address 0x1090.
//
`timescale 1ns/10ps
module rde_config_bank
  import rde_pkg::*;
#(
  parameter int TICKS_PER_SEC = SECOND_NS / CLK_PERIOD_NS,
  parameter int NUM_RELAYS    = 4,
  parameter int NUM_OUTPUTS   = 5
)
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [15:0]            reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [15:0]            reg_wdata,
  output      logic [15:0]            reg_rdata_q,
  output      logic                   reg_ack_q,
  output      logic                   reg_err_q,
  input  wire logic                   model_grid_tied,
  input  wire logic                   model_solar,
  input  wire logic [3:0]             alarm_flags,
  input  wire logic                   inv_fault,
  input  wire logic                   inv_on,
  input  wire logic [NUM_OUTPUTS-1:0] input_pin_state,
  output      logic [NUM_RELAYS-1:0]  relay_close_q,
  output      logic [NUM_OUTPUTS-1:0] output_pin_state_q,
  output      logic                   bypass_charger_enable_q,
  output      logic                   grid_feed_enable_q,
  output      logic [1:0]             operating_mode_select_q,
  output      logic [1:0]             charger_source_select_q,
  output      logic                   fetch_req_q,
  output      rde_pkg::rde_area_e     fetch_area_q,
  output      logic [12:0]            fetch_word_q,
  output      logic [7:0]             fetch_cmd_q,
  input  wire logic                   fetch_done,
  input  wire logic                   fetch_empty,
  input  wire logic [15:0]            fetch_data,
  input  wire logic                   evt_wr,
  input  wire logic                   evt_from_inv,
  input  wire logic [7:0]             evt_unit,
  input  wire logic [3:0]             evt_code,
  output      logic                   evt_ok_q,
  output      logic                   evt_bad_q
);

  localparam int CH = NUM_RELAYS + NUM_OUTPUTS;

  typedef enum logic [0:0] {ST_IDLE, ST_FETCH} rde_state_e;

  // ****************************************************************
  // Storage
  // ****************************************************************
  rde_state_e  state_q;
  logic [15:0] oper_q;
  logic [15:0] conf_q;
  logic [15:0] unit_sel_q;
  logic [15:0] relay_set_q [NUM_RELAYS];
  logic [15:0] dout_set_q  [NUM_OUTPUTS];
  logic [31:0] tick_cnt_q;
  logic        sec_tick_q;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire hit_oper   = (reg_addr == ADDR_OPERATION);
  wire hit_conf   = (reg_addr == ADDR_CONFIG);
  wire hit_relay  = (reg_addr >= ADDR_RELAY_FIRST) && (reg_addr <= ADDR_RELAY_LAST);
  wire hit_dout   = (reg_addr >= ADDR_DOUT_FIRST) && (reg_addr <= ADDR_DOUT_LAST);
  wire hit_rstate = (reg_addr == ADDR_RELAY_STATE);
  wire hit_dio    = (reg_addr == ADDR_DIO_STATE);
  wire hit_usel   = (reg_addr == ADDR_UNIT_SELECT);
  wire hit_num    = (reg_addr >= ADDR_NUM_FIRST) && (reg_addr <= ADDR_NUM_LAST);
  wire hit_str    = (reg_addr >= ADDR_STR_FIRST) && (reg_addr <= ADDR_STR_LAST);
  wire hit_log    = (reg_addr >= ADDR_LOG_FIRST) && (reg_addr <= ADDR_LOG_LAST);
  wire hit_rw     = hit_oper | hit_conf | hit_relay | hit_dout | hit_usel;
  wire hit_ro     = hit_rstate | hit_dio;
  wire hit_area   = hit_num | hit_str | hit_log;

  wire [15:0] relay_off = reg_addr - ADDR_RELAY_FIRST;
  wire [15:0] dout_off  = reg_addr - ADDR_DOUT_FIRST;
  wire [1:0]  relay_idx = relay_off[1:0];
  wire [2:0]  dout_idx  = dout_off[2:0];
  wire        idle      = (state_q == ST_IDLE);
  wire        wr_ok     = idle && reg_wr && !reg_rd && hit_rw;

  // Word offset of the access inside the area it falls in.
  wire [15:0] num_off = reg_addr - ADDR_NUM_FIRST;
  wire [15:0] str_off = reg_addr - ADDR_STR_FIRST;
  wire [15:0] log_off = reg_addr - ADDR_LOG_FIRST;

  // ****************************************************************
  // Model masking of the control fields
  // ****************************************************************
  // Features the attached model lacks read and act as zero.
  wire       bypass_charger_enable_eff  = oper_q[BIT_CHARGER];
  wire       grid_eff    = oper_q[BIT_GRID_FEED] & model_grid_tied;
  wire [1:0] mode_raw    = conf_q[1:0];
  wire [1:0] chg_raw     = conf_q[3:2];
  wire       mode_drop   = (mode_raw == MODE_SOLAR) && !model_solar;
  wire       chg_drop    = (chg_raw == CHG_SOLAR) && !model_solar;
  wire [1:0] mode_eff    = mode_drop ? MODE_UPS : mode_raw;
  wire [1:0] chg_eff     = chg_drop ? CHG_UTILITY : chg_raw;

  wire [15:0] oper_rd = {12'h000, grid_eff, bypass_charger_enable_eff, 2'h0};
  wire [15:0] conf_rd = {12'h000, chg_eff, mode_eff};

  // Unit query selection: type in the high byte, command in the low byte.
  wire [7:0] usel_type = unit_sel_q[15:8];
  wire [7:0] usel_cmd  = unit_sel_q[7:0];
  wire       num_cmd_ok = (usel_type == UNIT_TYPE_INV) && (usel_cmd <= NUM_CMD_LAST);
  wire       str_cmd_ok = (usel_type == UNIT_TYPE_INV) && (usel_cmd >= STR_CMD_FIRST)
                          && (usel_cmd <= STR_CMD_LAST);

  // ****************************************************************
  // Condition evaluation per channel
  // ****************************************************************
  // Returns whether a source meets its trigger right now.
  function automatic logic cond_of(input logic [3:0] src, input logic [3:0] trg,
                                   input logic [3:0] alm, input logic flt,
                                   input logic on, input logic [4:0] pins);
    logic [2:0] ch;
    logic       lvl;
    ch  = 3'(src - SRC_PIN_LO);
    lvl = 1'b0;
    cond_of = 1'b0;
    if (src == SRC_ALARM) begin
      case (trg)
        TRG_ANY:   cond_of = (|alm) | flt;
        TRG_OVP:   cond_of = alm[0];
        TRG_OTP:   cond_of = alm[1];
        TRG_OLP:   cond_of = alm[2];
        TRG_FAULT: cond_of = flt;
        default:   cond_of = 1'b0;
      endcase
    end else if (src == SRC_INV) begin
      if (trg == TRG_ON) begin
        cond_of = on;
      end else if (trg == TRG_OFF) begin
        cond_of = !on;
      end
    end else if ((src >= SRC_PIN_LO) && (src <= SRC_PIN_HI)) begin
      lvl = pins[ch];
      if (trg == TRG_HIGH) begin
        cond_of = lvl;
      end else if (trg == TRG_LOW) begin
        cond_of = !lvl;
      end
    end
  endfunction

  logic [CH-1:0] ch_cond;
  logic [CH-1:0] ch_active;
  logic [3:0]    ch_delay [CH];
  logic [4:0]    pins5;

  assign pins5 = 5'(input_pin_state);

  // Unpack the setting words into per-channel condition and delay.
  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      if (g < NUM_RELAYS) begin : g_relay
        assign ch_delay[g] = relay_set_q[g][3:0];
        assign ch_cond[g]  = cond_of(relay_set_q[g][11:8], relay_set_q[g][7:4],
                                     alarm_flags, inv_fault, inv_on, pins5);
      end else begin : g_dout
        assign ch_delay[g] = dout_set_q[g-NUM_RELAYS][3:0];
        assign ch_cond[g]  = cond_of(dout_set_q[g-NUM_RELAYS][15:12],
                                     dout_set_q[g-NUM_RELAYS][11:8],
                                     alarm_flags, inv_fault, inv_on, pins5);
      end
      rde_delay_timer u_timer (
        .clk        (clk),
        .srst       (srst),
        .cond       (ch_cond[g]),
        .sec_tick   (sec_tick_q),
        .delay_code (ch_delay[g]),
        .active_q   (ch_active[g])
      );
    end
  endgenerate

  // Output level per channel: action 0 fires high, any other fires low.
  logic [NUM_OUTPUTS-1:0] dout_level;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_lvl
      wire fire_high = (dout_set_q[g][7:4] == ACT_HIGH);
      assign dout_level[g] = ch_active[NUM_RELAYS+g] ? fire_high : !fire_high;
    end
  endgenerate

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_oper) begin
      rd_mux = oper_rd;
    end else if (hit_conf) begin
      rd_mux = conf_rd;
    end else if (hit_relay) begin
      rd_mux = {4'h0, relay_set_q[relay_idx][11:0]};
    end else if (hit_dout) begin
      rd_mux = dout_set_q[dout_idx];
    end else if (hit_rstate) begin
      rd_mux = {12'h000, 4'(relay_close_q)};
    end else if (hit_dio) begin
      rd_mux = {3'h0, pins5, 3'h0, 5'(output_pin_state_q)};
    end else if (hit_usel) begin
      rd_mux = unit_sel_q;
    end
  end

  // Area access needs an outside fetch unless the query is not served.
  wire area_serve = hit_log | (hit_num & num_cmd_ok) | (hit_str & str_cmd_ok);

  // ****************************************************************
  // One-second tick
  // ****************************************************************
  // Seconds base shared by all delay timers.
  always_ff @(posedge clk) begin
    if (srst || sec_tick_q) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= (tick_cnt_q == 32'(TICKS_PER_SEC - 2));
    end
  end

  // ****************************************************************
  // Setting registers
  // ****************************************************************
  // Operation and configuration words.
  always_ff @(posedge clk) begin
    if (srst) begin
      oper_q     <= OPERATION_RESET;
      conf_q     <= CONFIG_RESET;
      unit_sel_q <= UNIT_SEL_RESET;
    end else if (wr_ok) begin
      if (hit_oper) begin
        oper_q <= reg_wdata & 16'h000c;
      end
      if (hit_conf) begin
        conf_q <= reg_wdata & 16'h000f;
      end
      if (hit_usel) begin
        unit_sel_q <= reg_wdata;
      end
    end
  end

  // Relay and output setting words.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_RELAYS; i++) relay_set_q[i] <= SETTING_RESET;
      for (int i = 0; i < NUM_OUTPUTS; i++) dout_set_q[i] <= SETTING_RESET;
    end else if (wr_ok && hit_relay) begin
      relay_set_q[relay_idx] <= {4'h0, reg_wdata[11:0]};
    end else if (wr_ok && hit_dout) begin
      dout_set_q[dout_idx] <= reg_wdata;
    end
  end

  // ****************************************************************
  // Pin and control outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      relay_close_q           <= '0;
      output_pin_state_q      <= '0;
      bypass_charger_enable_q <= 1'b1;
      grid_feed_enable_q      <= 1'b0;
      operating_mode_select_q <= MODE_UPS;
      charger_source_select_q <= CHG_UTILITY;
    end else begin
      relay_close_q           <= ch_active[NUM_RELAYS-1:0];
      output_pin_state_q      <= dout_level;
      bypass_charger_enable_q <= bypass_charger_enable_eff;
      grid_feed_enable_q      <= grid_eff;
      operating_mode_select_q <= mode_eff;
      charger_source_select_q <= chg_eff;
    end
  end

  // ****************************************************************
  // Register answer and area fetch
  // ****************************************************************
  // Local words and unserved area queries answer in one cycle; served area words wait for the store.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q      <= ST_IDLE;
      reg_ack_q    <= 1'b0;
      reg_err_q    <= 1'b0;
      reg_rdata_q  <= 16'h0000;
      fetch_req_q  <= 1'b0;
      fetch_area_q <= AREA_NUM;
      fetch_word_q <= '0;
      fetch_cmd_q  <= 8'h00;
    end else begin
      reg_ack_q   <= 1'b0;
      reg_err_q   <= 1'b0;
      fetch_req_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (reg_rd && hit_area && area_serve) begin
            state_q      <= ST_FETCH;
            fetch_req_q  <= 1'b1;
            fetch_cmd_q  <= usel_cmd;
            fetch_area_q <= hit_log ? AREA_LOG : (hit_num ? AREA_NUM : AREA_STR);
            fetch_word_q <= hit_log ? log_off[12:0]
                          : (hit_num ? num_off[12:0] : str_off[12:0]);
          end else if (reg_rd) begin
            reg_ack_q   <= hit_rw | hit_ro | hit_area;
            reg_err_q   <= !(hit_rw | hit_ro | hit_area);
            reg_rdata_q <= rd_mux;
          end else if (reg_wr) begin
            reg_ack_q <= hit_rw;
            reg_err_q <= !hit_rw;
          end
        end
        ST_FETCH: begin
          if (fetch_done) begin
            state_q     <= ST_IDLE;
            reg_ack_q   <= 1'b1;
            reg_rdata_q <= fetch_empty ? 16'h0000 : fetch_data;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Event record check
  // ****************************************************************
  // Accepts only event codes that a record of that source may carry.
  wire sys_evt_ok = !evt_from_inv && (evt_code != 4'h0) && (evt_code <= SYS_EVT_LAST);
  wire inv_evt_ok = evt_from_inv && (evt_unit <= INV_UNIT_LAST)
                    && (evt_code != 4'h0) && (evt_code <= INV_EVT_LAST);

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_ok_q  <= 1'b0;
      evt_bad_q <= 1'b0;
    end else begin
      evt_ok_q  <= evt_wr && (sys_evt_ok || inv_evt_ok);
      evt_bad_q <= evt_wr && !(sys_evt_ok || inv_evt_ok);
    end
  end

endmodule

// ==== design/rde_delay_timer.sv ====
//
// Purpose: One delayed switch for a relay or digital output channel.
// Assumes: sec_tick pulses once each second.
// Notes:   The channel drops at once when its condition goes away.
//
`timescale 1ns/10ps
module rde_delay_timer
  import rde_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cond,
  input  wire logic       sec_tick,
  input  wire logic [3:0] delay_code,
  output      logic       active_q
);

  logic [9:0] sec_q;
  logic [9:0] target;
  logic       reached;

  // Whole seconds that must pass before the channel switches.
  assign target  = DELAY_SEC[delay_code];
  assign reached = (sec_q >= target);

  // Count held seconds while the condition stands, switch when reached.
  always_ff @(posedge clk) begin
    if (srst || !cond) begin
      active_q <= 1'b0;
      sec_q    <= '0;
    end else if (!active_q) begin
      if (reached) begin
        active_q <= 1'b1;
      end else if (sec_tick) begin
        sec_q <= sec_q + 10'd1;
      end
    end
  end

endmodule

// ==== design/rde_pkg.sv ====
//
// Purpose: Shared constants for the relay, digital output and event setting bank.
// Assumes: 16-bit register words addressed by a 16-bit word address.
// Notes:   Addresses are word addresses as seen by the protocol handler.
//
package rde_pkg;

  // ****************************************************************
  // Register word addresses
  // ****************************************************************
  localparam logic [15:0] ADDR_OPERATION   = 16'h0100;
  localparam logic [15:0] ADDR_CONFIG      = 16'h0101;
  localparam logic [15:0] ADDR_RELAY_FIRST = 16'h1080;
  localparam logic [15:0] ADDR_RELAY_LAST  = 16'h1083;
  localparam logic [15:0] ADDR_DOUT_FIRST  = 16'h1084;
  localparam logic [15:0] ADDR_DOUT_LAST   = 16'h1088;
  localparam logic [15:0] ADDR_RELAY_STATE = 16'h1090;
  localparam logic [15:0] ADDR_DIO_STATE   = 16'h1091;
  localparam logic [15:0] ADDR_UNIT_SELECT = 16'h1092;
  localparam logic [15:0] ADDR_NUM_FIRST   = 16'h2000;
  localparam logic [15:0] ADDR_NUM_LAST    = 16'h20bf;
  localparam logic [15:0] ADDR_STR_FIRST   = 16'h20d0;
  localparam logic [15:0] ADDR_STR_LAST    = 16'h284f;
  localparam logic [15:0] ADDR_LOG_FIRST   = 16'h3000;
  localparam logic [15:0] ADDR_LOG_LAST    = 16'h4f3f;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          BIT_CHARGER      = 2;
  localparam int          BIT_GRID_FEED    = 3;
  localparam logic [15:0] OPERATION_RESET  = 16'h0004;
  localparam logic [15:0] CONFIG_RESET     = 16'h0000;
  localparam logic [15:0] SETTING_RESET    = 16'h0000;
  localparam logic [15:0] UNIT_SEL_RESET   = 16'h0000;
  localparam logic [1:0]  MODE_UPS         = 2'h0;
  localparam logic [1:0]  MODE_SAVING      = 2'h1;
  localparam logic [1:0]  MODE_SOLAR       = 2'h2;
  localparam logic [1:0]  CHG_UTILITY      = 2'h0;
  localparam logic [1:0]  CHG_SOLAR        = 2'h1;

  // ****************************************************************
  // Source, trigger and action codes
  // ****************************************************************
  localparam logic [3:0] SRC_ALARM    = 4'h0;
  localparam logic [3:0] SRC_INV      = 4'h2;
  localparam logic [3:0] SRC_PIN_LO   = 4'h3;
  localparam logic [3:0] SRC_PIN_HI   = 4'h7;
  localparam logic [3:0] TRG_ON       = 4'h7;
  localparam logic [3:0] TRG_OFF      = 4'h8;
  localparam logic [3:0] TRG_HIGH     = 4'h9;
  localparam logic [3:0] TRG_LOW      = 4'ha;
  localparam logic [3:0] TRG_ANY      = 4'hb;
  localparam logic [3:0] TRG_OVP      = 4'hc;
  localparam logic [3:0] TRG_OTP      = 4'hd;
  localparam logic [3:0] TRG_OLP      = 4'he;
  localparam logic [3:0] TRG_FAULT    = 4'hf;
  localparam logic [3:0] ACT_HIGH     = 4'h0;

  // ****************************************************************
  // Delay table in seconds, indexed by the delay code
  // ****************************************************************
  localparam logic [15:0][9:0] DELAY_SEC = {
    10'd0,   10'd600, 10'd540, 10'd480, 10'd420, 10'd360, 10'd300, 10'd240,
    10'd180, 10'd120, 10'd60,  10'd30,  10'd10,  10'd5,   10'd1,   10'd0};

  // ****************************************************************
  // Unit data and event codes
  // ****************************************************************
  localparam logic [7:0] UNIT_TYPE_INV  = 8'h00;
  localparam logic [7:0] NUM_CMD_LAST   = 8'h06;
  localparam logic [7:0] STR_CMD_FIRST  = 8'h80;
  localparam logic [7:0] STR_CMD_LAST   = 8'h82;
  localparam logic [3:0] SYS_EVT_LAST   = 4'h6;
  localparam logic [3:0] INV_EVT_LAST   = 4'hc;
  localparam logic [7:0] INV_UNIT_LAST  = 8'h1f;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SECOND_NS     = 1000000000;
  localparam int CLK_PERIOD_NS = 5;

  typedef enum logic [1:0] {AREA_NUM, AREA_STR, AREA_LOG} rde_area_e;

endpackage

// ==== verif/rde_bank_props.sv ====
// Purpose: Port-level properties of the setting bank.
// Assumes: Bound to every instance of the bank.
// Notes:   Requests made while a fetch is pending are not checked.
`timescale 1ns/10ps
module rde_bank_props
  import rde_pkg::*;
(
  input wire logic        clk, srst, reg_wr, reg_rd, reg_ack_q, reg_err_q, fetch_req_q,
  input wire logic        fetch_done, evt_wr, evt_ok_q, evt_bad_q, model_grid_tied,
  input wire logic        grid_feed_enable_q, bypass_charger_enable_q,
  input wire logic [15:0] reg_addr, reg_rdata_q,
  input wire logic [3:0]  relay_close_q
);
  logic pend_q, done_q;
  wire  idle = !fetch_req_q && !pend_q;
  // Marks a fetch from its request until the cycle after its answer.
  always_ff @(posedge clk) begin
    done_q <= fetch_done;
    pend_q <= !srst && (fetch_req_q || (pend_q && !done_q));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wr(logic [15:0] a); reg_wr && !reg_rd && idle && reg_addr == a; endsequence
  sequence s_num_rd; reg_rd && idle && reg_addr >= ADDR_NUM_FIRST && reg_addr <= ADDR_NUM_LAST;
  endsequence
  property p_wr_ack; s_wr(ADDR_OPERATION) |=> reg_ack_q && !reg_err_q; endproperty
  property p_ro_err; s_wr(ADDR_RELAY_STATE) |=> reg_err_q && !reg_ack_q; endproperty
  property p_state_rd; reg_rd && idle && reg_addr == ADDR_RELAY_STATE
    |=> reg_ack_q && reg_rdata_q == {12'h000, $past(relay_close_q)}; endproperty
  property p_num_rd; s_num_rd |=> fetch_req_q || (reg_ack_q && reg_rdata_q == 16'h0000);
  endproperty
  property p_fetch_ans; pend_q && fetch_done |=> reg_ack_q; endproperty
  property p_evt; evt_wr |=> evt_ok_q != evt_bad_q; endproperty
  property p_grid; grid_feed_enable_q |-> $past(model_grid_tied); endproperty
  property p_chg_rst; $fell(srst) |-> bypass_charger_enable_q && !grid_feed_enable_q; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");
  a_ro_err: assert property (p_ro_err) else $error("status write not refused");
  a_state_rd: assert property (p_state_rd) else $error("relay status wrong");
  a_num_rd: assert property (p_num_rd) else $error("numeric read wrong");
  a_fetch_ans: assert property (p_fetch_ans) else $error("fetch not answered");
  a_evt: assert property (p_evt) else $error("event verdict wrong");
  a_grid: assert property (p_grid) else $error("grid feed on wrong model");
  a_chg_rst: assert property (p_chg_rst) else $error("reset levels wrong");
endmodule
bind rde_config_bank rde_bank_props i_props (.*);

// ==== verif/rde_store_model.sv ====
// Purpose: Outside store answering area fetches of the setting bank.
// Assumes: One fetch outstanding at a time.
// Notes:   Data between answers flips every cycle so stale words never match.
`timescale 1ns/10ps
module rde_store_model
  import rde_pkg::*;
(
  input  wire logic        clk, slow, fetch_req_q,
  input  wire rde_area_e   fetch_area_q,
  input  wire logic [12:0] fetch_word_q,
  output logic             fetch_done = 1'b0,
  output logic             fetch_empty = 1'b0,
  output logic [15:0]      fetch_data = 16'h5a5a
);
  logic [3:0] cnt_q = 4'h0;
  // Answers three or seven cycles after a request; the word encodes area and offset.
  always @(posedge clk) begin
    fetch_done  <= cnt_q == 4'h1;
    fetch_empty <= cnt_q == 4'h1 && fetch_area_q == AREA_LOG && fetch_word_q[0];
    fetch_data  <= cnt_q == 4'h1 ? {3'(fetch_area_q), fetch_word_q} : ~fetch_data;
    cnt_q       <= fetch_req_q ? (slow ? 4'h6 : 4'h2) : cnt_q - 4'(cnt_q != 4'h0);
  end
endmodule

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the setting bank.
// Assumes: One second is shortened to 20 cycles.
// Notes:   Area words come from the store model.
`timescale 1ns/10ps
module testbench;
  import rde_pkg::*;
  logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, model_grid_tied = 0, model_solar = 0;
  logic inv_fault = 0, inv_on = 0, evt_wr = 0, evt_from_inv = 0, slow = 0, fetch_done;
  logic fetch_empty, reg_ack_q, reg_err_q, evt_ok_q, evt_bad_q, fetch_req_q;
  logic bypass_charger_enable_q, grid_feed_enable_q;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q, fetch_data;
  logic [3:0] alarm_flags = 0, evt_code = 0, relay_close_q;
  logic [4:0] input_pin_state = 0, output_pin_state_q;
  logic [1:0] operating_mode_select_q, charger_source_select_q;
  logic [12:0] fetch_word_q;
  logic [7:0] fetch_cmd_q, evt_unit = 0;
  rde_area_e fetch_area_q;
  int n_fail = 0, total_checks = 0;
  rde_config_bank #(.TICKS_PER_SEC(20)) i_dut (.*);
  rde_store_model i_store (.*);
  always #2.5 clk = ~clk;
  // Compares one result word and counts it.
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // One register access, then its error flag and read data.
  task automatic ac(logic w, logic [15:0] a, logic [15:0] d, logic [15:0] e, logic x);
    int n;
    n = 0;
    @(posedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1;
    while (!(reg_ack_q | reg_err_q) && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("err", 16'(x), 16'(reg_err_q));
    chk("ack", 16'(!x), 16'(reg_ack_q));
    if (!w && !x) chk("rdata", e, reg_rdata_q);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Offers one event record and checks the verdict pulse.
  task automatic ev(logic i, logic [7:0] u, logic [3:0] c, logic k);
    @(posedge clk);
    {evt_wr, evt_from_inv, evt_unit, evt_code} <= {1'b1, i, u, c};
    @(posedge clk);
    evt_wr <= 1'b0;
    #1;
    chk("verdict", 16'({k, !k}), 16'({evt_ok_q, evt_bad_q}));
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence of register, relay, output, area and event tests.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    ac(0, 16'h0100, 0, 16'h0004, 0);
    ac(0, 16'h0101, 0, 16'h0000, 0);
    ac(1, 16'h0100, 16'h000c, 0, 0);
    ac(0, 16'h0100, 0, 16'h0004, 0);
    @(posedge clk) model_grid_tied <= 1;
    ac(0, 16'h0100, 0, 16'h000c, 0);
    chk("grid", 16'h0001, 16'(grid_feed_enable_q));
    ac(1, 16'h0101, 16'h0006, 0, 0);
    ac(0, 16'h0101, 0, 16'h0000, 0);
    @(posedge clk) model_solar <= 1;
    ac(0, 16'h0101, 0, 16'h0006, 0);
    chk("mode", 16'h0009, 16'({operating_mode_select_q, charger_source_select_q}));
    ac(1, 16'h1080, 16'hf390, 0, 0);
    ac(0, 16'h1080, 0, 16'h0390, 0);
    ac(1, 16'h1081, 16'h0272, 0, 0);
    ac(1, 16'h1084, 16'h0c10, 0, 0);
    wt(4);
    chk("idle", 16'h0001, 16'(output_pin_state_q));
    @(posedge clk) {input_pin_state, alarm_flags, inv_on} <= {5'h01, 4'h1, 1'b1};
    wt(4);
    chk("relay", 16'h0001, 16'(relay_close_q));
    chk("dout", 16'h0000, 16'(output_pin_state_q));
    ac(0, 16'h1090, 0, 16'h0001, 0);
    ac(0, 16'h1091, 0, 16'h0100, 0);
    wt(60);
    chk("early", 16'h0001, 16'(relay_close_q));
    wt(50);
    chk("late", 16'h0003, 16'(relay_close_q));
    @(posedge clk) input_pin_state <= 5'h00;
    wt(3);
    chk("open", 16'h0002, 16'(relay_close_q));
    ac(1, 16'h1092, 16'h0000, 0, 0);
    ac(0, 16'h2005, 0, 16'h0005, 0);
    ac(1, 16'h1092, 16'h0080, 0, 0);
    ac(0, 16'h20d1, 0, 16'h2001, 0);
    chk("cmd", 16'h0080, 16'(fetch_cmd_q));
    ac(0, 16'h2000, 0, 16'h0000, 0);
    slow = 1;
    ac(0, 16'h3001, 0, 16'h0000, 0);
    ac(0, 16'h3002, 0, 16'h4002, 0);
    ac(0, 16'h0500, 0, 0, 1);
    ac(1, 16'h1090, 16'h0001, 0, 1);
    ev(0, 8'h00, 4'h6, 1);
    ev(0, 8'h00, 4'h7, 0);
    ev(1, 8'h1f, 4'hc, 1);
    ev(1, 8'h20, 4'h1, 0);
    give_verdict;
  end
  // Cuts a hang short well after the tests should have ended.
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule
